// [inc/kvs_pkg.sv]
package kvs_pkg;
   // ************************************************************
   // link timing
   // ************************************************************
   localparam int unsigned CLK_HZ       = 40000000;
   localparam int unsigned BAUD_DEFAULT = 115200;
   localparam int unsigned BAUD_MIN     = 9600;
   localparam int unsigned BAUD_MAX     = 921600;
   localparam int unsigned DIV_W        = 16;
   localparam logic [15:0] DIV_DEFAULT  = 16'(CLK_HZ / BAUD_DEFAULT);
   localparam int unsigned DATA_BITS    = 8;
   localparam int unsigned FIFO_DEPTH   = 4;
   // ************************************************************
   // reset values and handshake modes
   // ************************************************************
   localparam logic        FLOW_RESET   = 1'b0;
   localparam logic        IDLE_LEVEL   = 1'b1;
   typedef enum logic [1:0] {
      kvs_hs_none   = 2'h0,
      kvs_hs_drive  = 2'h1,
      kvs_hs_sample = 2'h2,
      kvs_hs_both   = 2'h3
   } kvs_hs_t;
endpackage

// [inc/kvs_link_if.sv]
`timescale 1ns/1ps
interface kvs_link_if;
   logic dev_tx;
   logic dev_rx;
   logic dev_cts;
   logic dev_rts;
   logic link_en;
   modport dev (output dev_tx, input dev_rx, input dev_cts, output dev_rts, output link_en);
   modport ctl (input dev_tx, output dev_rx, output dev_cts, input dev_rts, input link_en);
endinterface

// [rtl/kvs_uart_core.sv]
`timescale 1ns/1ps
module kvs_uart_core #(
   parameter int unsigned DEPTH = kvs_pkg::FIFO_DEPTH
) (
   input  wire logic              ref_clk_i,
   input  wire logic              arst_n_i,
   input  wire logic [15:0]       div_i,
   input  wire logic              tx_pause_i,
   input  wire logic              rx_line_i,
   input  wire logic              tx_valid_i,
   input  wire logic [7:0]        tx_data_i,
   output logic                   tx_ready_o,
   output logic                   tx_line_o,
   output logic                   tx_busy_o,
   output logic                   rx_valid_o,
   output logic [7:0]             rx_data_o
);
   // ************************************************************
   // shared serialiser / deserialiser for both ends
   // ************************************************************
   typedef enum logic [1:0] {kvs_idle, kvs_start, kvs_data, kvs_stop} kvs_st_t;
   kvs_st_t     tx_st;
   kvs_st_t     rx_st;
   logic [15:0] tx_cnt;
   logic [15:0] rx_cnt;
   logic [2:0]  tx_bit;
   logic [2:0]  rx_bit;
   logic [7:0]  tx_sh;
   logic [7:0]  rx_sh;
   logic        rx_s1;
   logic        rx_s2;
   wire         tx_tick  = (tx_cnt == 16'h0000);
   wire         rx_tick  = (rx_cnt == 16'h0000);
   wire [15:0]  div_m1   = div_i - 16'h0001;
   wire [15:0]  half_div = {1'b0, div_i[15:1]};
   wire         tx_take  = (tx_st == kvs_idle) && tx_valid_i && !tx_pause_i;
   assign tx_ready_o = (tx_st == kvs_idle) && !tx_pause_i;
   assign tx_busy_o  = (tx_st != kvs_idle);

   // ************************************************************
   // transmitter
   // ************************************************************
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_st     <= kvs_idle;
         tx_cnt    <= 16'h0000;
         tx_bit    <= 3'h0;
         tx_sh     <= 8'h00;
         tx_line_o <= kvs_pkg::IDLE_LEVEL;
      end else begin
         tx_cnt <= tx_tick ? div_m1 : tx_cnt - 16'h0001;
         case (tx_st)
            kvs_idle: begin
               tx_line_o <= 1'b1;
               if (tx_take) begin
                  tx_sh     <= tx_data_i;
                  tx_cnt    <= div_m1;
                  tx_line_o <= 1'b0;
                  tx_st     <= kvs_start;
               end
            end
            kvs_start: if (tx_tick) begin
               tx_line_o <= tx_sh[0];
               tx_sh     <= {1'b0, tx_sh[7:1]};
               tx_bit    <= 3'h0;
               tx_st     <= kvs_data;
            end
            kvs_data: if (tx_tick) begin
               if (tx_bit == 3'h7) begin
                  tx_line_o <= 1'b1;
                  tx_st     <= kvs_stop;
               end else begin
                  tx_line_o <= tx_sh[0];
                  tx_sh     <= {1'b0, tx_sh[7:1]};
                  tx_bit    <= tx_bit + 3'h1;
               end
            end
            kvs_stop: if (tx_tick) tx_st <= kvs_idle;
            default: tx_st <= kvs_idle;
         endcase
      end
   end

   // ************************************************************
   // receiver, line sampled mid bit after two flops
   // ************************************************************
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_s1      <= 1'b1;
         rx_s2      <= 1'b1;
         rx_st      <= kvs_idle;
         rx_cnt     <= 16'h0000;
         rx_bit     <= 3'h0;
         rx_sh      <= 8'h00;
         rx_valid_o <= 1'b0;
         rx_data_o  <= 8'h00;
      end else begin
         rx_s1      <= rx_line_i;
         rx_s2      <= rx_s1;
         rx_valid_o <= 1'b0;
         rx_cnt     <= rx_tick ? div_m1 : rx_cnt - 16'h0001;
         case (rx_st)
            kvs_idle: if (!rx_s2) begin
               rx_cnt <= half_div;
               rx_st  <= kvs_start;
            end
            kvs_start: if (rx_tick) begin
               rx_bit <= 3'h0;
               rx_st  <= rx_s2 ? kvs_idle : kvs_data; // glitch rejected
            end
            kvs_data: if (rx_tick) begin
               rx_sh <= {rx_s2, rx_sh[7:1]};
               rx_bit <= rx_bit + 3'h1;
               if (rx_bit == 3'h7) rx_st <= kvs_stop;
            end
            kvs_stop: if (rx_tick) begin
               // framing error: character dropped
               rx_valid_o <= rx_s2;
               rx_data_o  <= rx_sh;
               rx_st      <= kvs_idle;
            end
            default: rx_st <= kvs_idle;
         endcase
      end
   end
endmodule

// [rtl/kvs_dev_end.sv]
`timescale 1ns/1ps
// device end: core plus small rx queue steering rts
module kvs_dev_end #(
   parameter int unsigned DEPTH = kvs_pkg::FIFO_DEPTH
) (
   input  wire logic              ref_clk_i,
   input  wire logic              arst_n_i,
   kvs_link_if.dev                link,
   input  wire logic              enable_i,
   input  wire logic              flow_en_i,
   input  wire logic [15:0]       div_i,
   input  wire logic              tx_valid_i,
   input  wire logic [7:0]        tx_data_i,
   output logic                   tx_ready_o,
   output logic                   rx_valid_o,
   output logic [7:0]             rx_data_o,
   input  wire logic              rx_ready_i
);
   // ************************************************************
   // pin sync and control flops
   // ************************************************************
   logic       cts_s1;
   logic       cts_s2;
   logic       en_q;
   logic       rts_q;
   logic [7:0] q_mem [DEPTH];
   logic [$clog2(DEPTH):0] q_cnt;
   logic [$clog2(DEPTH)-1:0] q_wr;
   logic [$clog2(DEPTH)-1:0] q_rd;
   logic       c_rdy;
   logic       c_txl;
   logic       c_rv;
   logic [7:0] c_rd;
   logic       c_busy;
   wire        pause   = !en_q || (flow_en_i && !cts_s2);
   wire        q_push  = c_rv && en_q && (q_cnt != ($clog2(DEPTH)+1)'(DEPTH));
   wire        q_pop   = rx_valid_o && rx_ready_i;
   // keep room for one more character after rts drops
   wire        room    = (q_cnt < ($clog2(DEPTH)+1)'(DEPTH - 1));

   kvs_uart_core #(.DEPTH(DEPTH)) u_core (
      .ref_clk_i  (ref_clk_i),
      .arst_n_i   (arst_n_i),
      .div_i      (div_i),
      .tx_pause_i (pause),
      .rx_line_i  (link.dev_rx),
      .tx_valid_i (tx_valid_i),
      .tx_data_i  (tx_data_i),
      .tx_ready_o (c_rdy),
      .tx_line_o  (c_txl),
      .tx_busy_o  (c_busy),
      .rx_valid_o (c_rv),
      .rx_data_o  (c_rd)
   );
   assign tx_ready_o   = c_rdy;
   assign link.dev_tx  = c_txl;
   assign link.dev_rts = rts_q;
   assign link.link_en = en_q;
   assign rx_valid_o   = (q_cnt != '0);
   assign rx_data_o    = q_mem[q_rd];

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cts_s1 <= 1'b0;
         cts_s2 <= 1'b0;
         en_q   <= 1'b0;
         rts_q  <= 1'b0;
         q_cnt  <= '0;
         q_wr   <= '0;
         q_rd   <= '0;
      end else begin
         cts_s1 <= link.dev_cts;
         cts_s2 <= cts_s1;
         en_q   <= enable_i;
         rts_q  <= room && en_q;
         if (q_push) begin
            q_mem[q_wr] <= c_rd;
            q_wr <= q_wr + 1'b1;
         end
         if (q_pop) q_rd <= q_rd + 1'b1;
         q_cnt <= q_cnt + (q_push ? 1'b1 : 1'b0) - (q_pop ? 1'b1 : 1'b0);
      end
   end
endmodule

// [rtl/kvs_ctl_end.sv]
`timescale 1ns/1ps
// controller end: handshake modes and host path choice
module kvs_ctl_end (
   input  wire logic              ref_clk_i,
   input  wire logic              arst_n_i,
   kvs_link_if.ctl                link,
   input  wire kvs_pkg::kvs_hs_t  hs_mode_i,
   input  wire logic [15:0]       div_i,
   input  wire logic              sock_conn_i,
   input  wire logic              usb_valid_i,
   input  wire logic [7:0]        usb_data_i,
   input  wire logic              sock_valid_i,
   input  wire logic [7:0]        sock_data_i,
   output logic                   host_ready_o,
   input  wire logic              host_full_i,
   output logic                   usb_valid_o,
   output logic                   sock_valid_o,
   output logic [7:0]             host_data_o
);
   // ************************************************************
   // pin sync and host relay
   // ************************************************************
   logic       rts_s1;
   logic       rts_s2;
   logic       en_s1;
   logic       en_s2;
   logic       cts_q;
   logic       c_rv;
   logic [7:0] c_rd;
   logic       c_txl;
   wire        use_rts = (hs_mode_i == kvs_pkg::kvs_hs_sample) ||
                         (hs_mode_i == kvs_pkg::kvs_hs_both);
   wire        drv_cts = (hs_mode_i == kvs_pkg::kvs_hs_drive) ||
                         (hs_mode_i == kvs_pkg::kvs_hs_both);
   wire        pause   = !en_s2 || (use_rts && !rts_s2);
   wire        in_v    = sock_conn_i ? sock_valid_i : usb_valid_i;
   wire [7:0]  in_d    = sock_conn_i ? sock_data_i : usb_data_i;

   kvs_uart_core u_core (
      .ref_clk_i  (ref_clk_i),
      .arst_n_i   (arst_n_i),
      .div_i      (div_i),
      .tx_pause_i (pause),
      .rx_line_i  (link.dev_tx),
      .tx_valid_i (in_v),
      .tx_data_i  (in_d),
      .tx_ready_o (host_ready_o),
      .tx_line_o  (c_txl),
      .tx_busy_o  (),
      .rx_valid_o (c_rv),
      .rx_data_o  (c_rd)
   );
   assign link.dev_rx  = c_txl;
   assign link.dev_cts = cts_q;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rts_s1       <= 1'b0;
         rts_s2       <= 1'b0;
         en_s1        <= 1'b0;
         en_s2        <= 1'b0;
         cts_q        <= 1'b1;
         usb_valid_o  <= 1'b0;
         sock_valid_o <= 1'b0;
         host_data_o  <= 8'h00;
      end else begin
         rts_s1       <= link.dev_rts;
         rts_s2       <= rts_s1;
         en_s1        <= link.link_en;
         en_s2        <= en_s1;
         // undriven in off modes: held asserted so target never stalls
         cts_q        <= drv_cts ? !host_full_i : 1'b1;
         usb_valid_o  <= c_rv && en_s2 && !sock_conn_i;
         sock_valid_o <= c_rv && en_s2 && sock_conn_i;
         host_data_o  <= c_rd;
      end
   end
endmodule

// [test/kvs_link_chk.sv]
`timescale 1ns/1ps
// ************
// frame checks on both serial lines
// ************
module kvs_link_chk (
   input  wire logic        ref_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic [15:0] div_i,
   input  wire logic        dev_tx,
   input  wire logic        dev_rx,
   input  wire logic        dev_cts,
   input  wire logic        dev_rts,
   input  wire logic        link_en
);
   // frame timing follows the live rate; it only changes while both lines idle
   logic [15:0] fr_last;
   logic [15:0] stop_at;
   logic [1:0]  ln;
   logic [1:0]  ln_q;
   logic [1:0]  go;
   logic [15:0] fc [2];
   assign fr_last = 16'(10 * div_i) - 16'h1;
   assign stop_at = 16'(9 * div_i);
   assign ln = {dev_rx, dev_tx};
   // restart only from idle, so falling data bits never resync the count
   assign go = ln_q & ~ln & {fc[1] == 16'h0, fc[0] == 16'h0};
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ln_q <= 2'h3;
         for (int i = 0; i < 2; i++) fc[i] <= 16'h0;
      end else begin
         ln_q <= ln;
         for (int i = 0; i < 2; i++) begin
            if (go[i]) begin
               fc[i] <= 16'h1;
            end else if (fc[i] != 16'h0) begin
               fc[i] <= (fc[i] == fr_last) ? 16'h0 : fc[i] + 16'h1;
            end
         end
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   tx_start_a: assert property (fc[0] != 16'h0 && fc[0] < div_i |-> !dev_tx)
      else $error("tx start bit not low");
   rx_start_a: assert property (fc[1] != 16'h0 && fc[1] < div_i |-> !dev_rx)
      else $error("rx start bit not low");
   tx_stop_a: assert property (fc[0] >= stop_at |-> dev_tx)
      else $error("tx stop bit not high");
   rx_stop_a: assert property (fc[1] >= stop_at |-> dev_rx)
      else $error("rx stop bit not high");
   tx_bits_a: assert property (fc[0] != 16'h0 && fc[0] % div_i != 16'h0 |-> $stable(dev_tx))
      else $error("tx bit changed inside its cell");
   rx_bits_a: assert property (fc[1] != 16'h0 && fc[1] % div_i != 16'h0 |-> $stable(dev_rx))
      else $error("rx bit changed inside its cell");
   tx_link_a: assert property (go[0] |-> link_en)
      else $error("tx frame while link disabled");
   rx_link_a: assert property (go[1] |-> link_en)
      else $error("rx frame while link disabled");
   cover property (go[0]);
   cover property (go[1]);
   cover property (link_en && !dev_rts && !dev_cts);
endmodule

// [test/test_kit_virtual_serial_link.sv]
`timescale 1ns/1ps
module test_kit_virtual_serial_link;
   localparam int DIV = int'(kvs_pkg::DIV_DEFAULT);
   logic             ref_clk_i, arst_n_i, enable_i, flow_en_i, tx_valid_i, tx_ready_o;
   logic             rx_valid_o, rx_ready_i, sock_conn_i, usb_valid_i, sock_valid_i;
   logic             host_ready_o, host_full_i, usb_valid_o, sock_valid_o;
   logic [7:0]       tx_data_i, rx_data_o, usb_data_i, sock_data_i, host_data_o;
   logic [15:0]      div_i;
   kvs_pkg::kvs_hs_t hs_mode_i;
   kvs_pkg::kvs_hs_t pm [2] = '{kvs_pkg::kvs_hs_drive, kvs_pkg::kvs_hs_both};
   int               n_fail = 0, cmp_count = 0, cyc = 0;
   kvs_link_if link ();
   kvs_dev_end u_kvs_dev_end (.ref_clk_i, .arst_n_i, .link(link), .enable_i, .flow_en_i,
      .div_i, .tx_valid_i, .tx_data_i, .tx_ready_o, .rx_valid_o, .rx_data_o, .rx_ready_i);
   kvs_ctl_end u_kvs_ctl_end (.ref_clk_i, .arst_n_i, .link(link), .hs_mode_i, .div_i,
      .sock_conn_i, .usb_valid_i, .usb_data_i, .sock_valid_i, .sock_data_i, .host_ready_o,
      .host_full_i, .usb_valid_o, .sock_valid_o, .host_data_o);
   kvs_link_chk u_kvs_link_chk (.ref_clk_i, .arst_n_i, .div_i, .dev_tx(link.dev_tx),
      .dev_rx(link.dev_rx), .dev_cts(link.dev_cts), .dev_rts(link.dev_rts),
      .link_en(link.link_en));
   // ************
   // clock, timeout, report
   // ************
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 90000) begin
         n_fail++;
         final_report();
      end
   end
   task final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task step(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   // ************
   // transfer helpers, all entered and left at a falling edge
   // ************
   task dev_send(input logic [7:0] d);
      int n;
      n = 0;
      while (tx_ready_o !== 1'b1 && n < 8000) begin
         step(1);
         n++;
      end
      chk("dev tx ready", 8'h01, {7'h0, tx_ready_o});
      tx_data_i = d;
      tx_valid_i = 1'b1;
      step(1);
      tx_valid_i = 1'b0;
   endtask
   task host_send(input logic s, input logic [7:0] d);
      int n;
      n = 0;
      while (host_ready_o !== 1'b1 && n < 8000) begin
         step(1);
         n++;
      end
      chk("ctl tx ready", 8'h01, {7'h0, host_ready_o});
      // usb offers a different byte while the socket owns the link
      {sock_data_i, usb_data_i} = {d, s ? ~d : d};
      {sock_valid_i, usb_valid_i} = {s, 1'b1};
      step(1);
      {sock_valid_i, usb_valid_i} = 2'h0;
   endtask
   task host_get(input logic s, input logic [7:0] d);
      int n;
      n = 0;
      while (usb_valid_o !== 1'b1 && sock_valid_o !== 1'b1 && n < 8000) begin
         step(1);
         n++;
      end
      chk("host data", d, host_data_o);
      chk("host path", {6'h0, s, !s}, {6'h0, sock_valid_o, usb_valid_o});
   endtask
   task dev_get(input logic [7:0] d);
      int n;
      n = 0;
      while (rx_valid_o !== 1'b1 && n < 8000) begin
         step(1);
         n++;
      end
      chk("dev rx valid", 8'h01, {7'h0, rx_valid_o});
      chk("dev data", d, rx_data_o);
      rx_ready_i = 1'b1;
      step(1);
      rx_ready_i = 1'b0;
   endtask
   // ************
   // scenarios
   // ************
   task t_paths;
      enable_i = 1'b1;
      step(4);
      chk("link enable", 8'h01, {7'h0, link.link_en});
      dev_send(8'ha5);
      host_get(1'b0, 8'ha5);
      host_send(1'b0, 8'h81);
      dev_get(8'h81);
      sock_conn_i = 1'b1;
      dev_send(8'h3c);
      host_get(1'b1, 8'h3c);
      host_send(1'b1, 8'h7e);
      dev_get(8'h7e);
   endtask
   task t_cts_pause;
      flow_en_i = 1'b1;
      for (int i = 0; i < 2; i++) begin
         hs_mode_i = pm[i];
         host_full_i = 1'b1;
         step(6);
         chk("cts when full", 8'h00, {7'h0, link.dev_cts});
         chk("dev tx ready", 8'h00, {7'h0, tx_ready_o});
         host_full_i = 1'b0;
         dev_send(8'hc3 + 8'(i));
         host_get(1'b1, 8'hc3 + 8'(i));
      end
   endtask
   task t_rts_hold;
      hs_mode_i = kvs_pkg::kvs_hs_sample;
      host_full_i = 1'b1;
      for (int i = 0; i < 3; i++) host_send(1'b1, 8'h10 + 8'(i));
      step(10 * DIV + 20);
      chk("cts sample mode", 8'h01, {7'h0, link.dev_cts});
      chk("rts near full", 8'h00, {7'h0, link.dev_rts});
      chk("ctl holds off", 8'h00, {7'h0, host_ready_o});
      for (int i = 0; i < 3; i++) dev_get(8'h10 + 8'(i));
      host_send(1'b1, 8'h13);
      dev_get(8'h13);
   endtask
   task t_rts_ignored;
      // fourth byte after rts drop must still fit the queue
      hs_mode_i = kvs_pkg::kvs_hs_none;
      for (int i = 0; i < 4; i++) host_send(1'b1, 8'h20 + 8'(i));
      chk("rts ignored", 8'h00, {7'h0, link.dev_rts});
      chk("cts none mode", 8'h01, {7'h0, link.dev_cts});
      for (int i = 0; i < 4; i++) dev_get(8'h20 + 8'(i));
   endtask
   task t_rate_max;
      // let the last stop bit end before the rate moves
      step(DIV);
      div_i = 16'(kvs_pkg::CLK_HZ / kvs_pkg::BAUD_MAX);
      step(2);
      dev_send(8'h5a);
      host_get(1'b1, 8'h5a);
      host_send(1'b1, 8'hc6);
      dev_get(8'hc6);
   endtask
   initial begin
      {arst_n_i, enable_i, flow_en_i, tx_valid_i, rx_ready_i} = 5'h0;
      {sock_conn_i, usb_valid_i, sock_valid_i, host_full_i} = 4'h0;
      {tx_data_i, usb_data_i, sock_data_i} = 24'h0;
      div_i = kvs_pkg::DIV_DEFAULT;
      hs_mode_i = kvs_pkg::kvs_hs_none;
      step(2);
      chk("reset lines", 8'h0e, {4'h0, link.dev_tx, link.dev_rx, link.dev_cts, link.dev_rts});
      arst_n_i = 1'b1;
      step(4);
      chk("tx ready disabled", 8'h00, {7'h0, tx_ready_o});
      t_paths();
      t_cts_pause();
      t_rts_hold();
      t_rts_ignored();
      t_rate_max();
      final_report();
   end
endmodule
